// *** design/psc_pkg.sv ***
// Package for the sensor control and interrupt pin register pair.
// Assumes a byte-wide register port driven by a serial protocol engine.
`default_nettype none
package psc_pkg;

   // Register offsets
   localparam logic [7:0] CTRL_OFFS      = 8'h11;
   localparam logic [7:0] PINSEL_OFFS    = 8'h12;

   // Control register field positions
   localparam int         CTL_RELOAD_BIT = 7;
   localparam int         CTL_POL_BIT    = 6;
   localparam int         CTL_DRIVE_BIT  = 5;
   localparam int         CTL_AINC_BIT   = 4;
   localparam int         CTL_CLEAR_BIT  = 2;
   localparam int         CTL_LNOISE_BIT = 1;
   localparam int         CTL_SHOT_BIT   = 0;

   // Pin source register field positions
   localparam int         PS_FULL_BIT    = 5;
   localparam int         PS_MARK_BIT    = 4;
   localparam int         PS_OVR_BIT     = 3;
   localparam int         PS_RDY_BIT     = 2;
   localparam int         PS_SRC_LSB     = 0;

   // Reset values; bit 3 of control and bits 7:6 of pin select read zero
   localparam logic [7:0] CTRL_RST       = 8'h10;
   localparam logic [7:0] PINSEL_RST     = 8'h00;
   localparam logic [7:0] CTRL_WMASK     = 8'hF7;
   localparam logic [7:0] PINSEL_WMASK   = 8'h3F;

   // Rate codes
   localparam logic [2:0] RATE_OFF       = 3'h0;
   localparam logic [2:0] RATE_100HZ     = 3'h6;
   localparam logic [2:0] RATE_200HZ     = 3'h7;

   // Pin source codes
   localparam logic [1:0] SRC_DATA       = 2'h0;
   localparam logic [1:0] SRC_PHIGH      = 2'h1;
   localparam logic [1:0] SRC_PLOW       = 2'h2;
   localparam logic [1:0] SRC_PEITHER    = 2'h3;

   // Timing counts
   localparam int         RELOAD_CYCLES  = 16;
   localparam int         CLEAR_CYCLES   = 4;

endpackage : psc_pkg
`default_nettype wire

// *** design/psc_seq.sv ***
// Small busy sequencer: a start pulse holds busy for a fixed count.
// Assumes start comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module psc_seq #(
   parameter int CYCLES = 16
) (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Control
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);
   localparam int CW = $clog2(CYCLES + 1);

   // Elaboration check: a zero count would still raise busy and then wrap the counter
   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("psc_seq: CYCLES must be at least 1");
   end

   logic [CW-1:0] cnt_q;
   wire           last_w = o_busy && (cnt_q == CW'(1));

   // Count down while busy; a start while busy is ignored
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cnt_q  <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= last_w;
         if (!o_busy && i_start)
         begin
            cnt_q  <= CW'(CYCLES);
            o_busy <= 1'b1;
         end
         else if (o_busy)
         begin
            cnt_q  <= cnt_q - CW'(1);
            o_busy <= !last_w;
         end
      end
   end
endmodule : psc_seq
`default_nettype wire

// *** design/psc_regs.sv ***
// Control register pair: trim reload, soft clear, measurement mode,
// single shot trigger and routing of events to the interrupt pin.
// Assumes a byte register port from a serial engine on i_clock and
// status inputs from the FIFO, threshold and conversion logic.
// Functional notes
// - Writing 1 to control bit 7 copies factory trim into trim registers.
// - Trim reload starts immediately on the write, unless a reload is already running.
// - Hardware clears the reload bit when the reload ends.
// - Bit 6 picks pin polarity: 0 active high, 1 active low; resets 0.
// - Bit 5 picks pin drive: 0 push-pull, 1 open-drain; resets 0.
// - Bit 4 enables address auto-increment; resets to 1.
// - Writing 1 to bit 2 clears volatile registers; bit self-clears after.
// - Bit 1 picks low-current (0) or low-noise (1); resets 0.
// - At 100 Hz or 200 Hz low-noise is forced off.
// - With rate 000, writing bit 0 starts one pressure and temperature sample.
// - After the shot, trigger self-clears, results load, status updates.
// - Pin select bit 5 routes FIFO full (128 samples) to the pin.
// - Bit 4 routes the FIFO watermark flag to the pin.
// - Bit 3 routes the FIFO overrun flag to the pin.
// - Bit 2 routes the new data ready indication to the pin.
// - Source field: 00 OR of enabled data flags, 01 high, 10 low, 11 either.
// - Single shot is honoured only when powered down; returns there after.
// - Rate codes 110 and 111 disable low-noise mode.
`timescale 1ns/1ps
`default_nettype none
module psc_regs #(
   parameter int TRIM_WORDS = 8
) (
   // Clock and reset
   input  wire logic                 i_clock,
   input  wire logic                 i_sys_rst,
   // Register port from the serial engine
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_rd,
   input  wire logic [7:0]           i_reg_addr,
   input  wire logic [7:0]           i_reg_wdata,
   output logic      [7:0]           o_reg_rdata,
   output logic                      o_addr_inc_en,
   // Rate field from the first control register
   input  wire logic [2:0]           i_output_rate_field,
   // Factory trim store
   input  wire logic [8*TRIM_WORDS-1:0] i_trim_nv,
   output logic      [8*TRIM_WORDS-1:0] o_trim,
   // Volatile clear to the rest of the register map
   output logic                      o_soft_reg_clear,
   // Conversion engine
   output logic                      o_shot_start,
   input  wire logic                 i_shot_done,
   output logic                      o_low_noise,
   // Event sources
   input  wire logic                 i_data_ready,
   input  wire logic                 i_fifo_level_mark,
   input  wire logic                 i_fifo_overrun,
   input  wire logic                 i_fifo_full,
   input  wire logic                 i_press_high,
   input  wire logic                 i_press_low,
   // Interrupt pin as two signals: level and drive enable
   output logic                      o_event_out_pin,
   output logic                      o_event_out_pin_oe
);
   // Elaboration check: the trim store needs at least one byte
   if (TRIM_WORDS < 1)
   begin : g_bad_trim
      $error("psc_regs: TRIM_WORDS must be at least 1");
   end

   logic [7:0] ctrl_q;
   logic [7:0] pinsel_q;
   logic       reload_busy;
   logic       reload_done;
   logic       clear_busy;
   logic       clear_done;
   logic       shot_busy_q;

   // Decode
   wire wr_ctrl_w   = i_reg_wr && (i_reg_addr == psc_pkg::CTRL_OFFS);
   wire wr_pinsel_w = i_reg_wr && (i_reg_addr == psc_pkg::PINSEL_OFFS);
   wire powered_dn_w = (i_output_rate_field == psc_pkg::RATE_OFF);
   wire fast_rate_w  = (i_output_rate_field == psc_pkg::RATE_100HZ)
                     || (i_output_rate_field == psc_pkg::RATE_200HZ);
   wire reload_go_w = wr_ctrl_w && i_reg_wdata[psc_pkg::CTL_RELOAD_BIT];
   wire clear_go_w  = wr_ctrl_w && i_reg_wdata[psc_pkg::CTL_CLEAR_BIT];
   // A trigger outside power-down is dropped rather than queued
   wire shot_go_w   = wr_ctrl_w && i_reg_wdata[psc_pkg::CTL_SHOT_BIT]
                    && powered_dn_w && !shot_busy_q;

   // Reload and clear sequencers
   psc_seq #(.CYCLES(psc_pkg::RELOAD_CYCLES)) u_reload (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_start   (reload_go_w),
      .o_busy    (reload_busy),
      .o_done    (reload_done)
   );
   psc_seq #(.CYCLES(psc_pkg::CLEAR_CYCLES)) u_clear (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_start   (clear_go_w),
      .o_busy    (clear_busy),
      .o_done    (clear_done)
   );

   // Self-clearing bits are the busy flags of their sequences
   wire [7:0] ctrl_rd_w = {reload_busy, ctrl_q[6:3], clear_busy, ctrl_q[1], shot_busy_q};

   // Control register; a clear write restores defaults for the stored bits
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         ctrl_q <= psc_pkg::CTRL_RST;
      else if (clear_go_w)
         ctrl_q <= psc_pkg::CTRL_RST;
      else if (wr_ctrl_w)
         ctrl_q <= i_reg_wdata & psc_pkg::CTRL_WMASK;
   end

   // Pin source register, also cleared by the soft clear
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         pinsel_q <= psc_pkg::PINSEL_RST;
      else if (clear_go_w)
         pinsel_q <= psc_pkg::PINSEL_RST;
      else if (wr_pinsel_w)
         pinsel_q <= i_reg_wdata & psc_pkg::PINSEL_WMASK;
   end

   // The bit drops at the end of the reload, then the trim copy lands one cycle later
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_trim <= '0;
      else if (reload_done)
         o_trim <= i_trim_nv;
   end

   // Single shot: busy from trigger until the engine reports done
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         shot_busy_q  <= 1'b0;
         o_shot_start <= 1'b0;
      end
      else
      begin
         o_shot_start <= shot_go_w;
         if (shot_go_w)
            shot_busy_q <= 1'b1;
         else if (i_shot_done)
            shot_busy_q <= 1'b0;
      end
   end

   // Pin source selection
   wire [1:0] src_w = pinsel_q[psc_pkg::PS_SRC_LSB +: 2];
   wire data_sig_w  = (pinsel_q[psc_pkg::PS_RDY_BIT]  && i_data_ready)
                    || (pinsel_q[psc_pkg::PS_MARK_BIT] && i_fifo_level_mark)
                    || (pinsel_q[psc_pkg::PS_OVR_BIT]  && i_fifo_overrun)
                    || (pinsel_q[psc_pkg::PS_FULL_BIT] && i_fifo_full);
   wire event_w = (src_w == psc_pkg::SRC_DATA)  ? data_sig_w :
                  (src_w == psc_pkg::SRC_PHIGH) ? i_press_high :
                  (src_w == psc_pkg::SRC_PLOW)  ? i_press_low :
                  (i_press_high || i_press_low);
   wire active_lo_w = ctrl_q[psc_pkg::CTL_POL_BIT];
   wire open_dr_w   = ctrl_q[psc_pkg::CTL_DRIVE_BIT];
   wire pin_lvl_w   = event_w ^ active_lo_w;
   // Open drain only pulls when the pin level is low, asserted or idle
   wire pin_oe_w    = open_dr_w ? (pin_lvl_w == 1'b0) : 1'b1;

   // Registered outputs
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_event_out_pin    <= 1'b0;
         o_event_out_pin_oe <= 1'b1;
         o_low_noise        <= 1'b0;
         o_addr_inc_en      <= 1'b1;
         o_soft_reg_clear   <= 1'b0;
         o_reg_rdata        <= 8'h00;
      end
      else
      begin
         o_event_out_pin    <= pin_lvl_w;
         o_event_out_pin_oe <= pin_oe_w;
         o_low_noise        <= ctrl_q[psc_pkg::CTL_LNOISE_BIT] && !fast_rate_w;
         o_addr_inc_en      <= ctrl_q[psc_pkg::CTL_AINC_BIT];
         o_soft_reg_clear   <= clear_busy;
         if (i_reg_rd)
            o_reg_rdata <= (i_reg_addr == psc_pkg::CTRL_OFFS)   ? ctrl_rd_w :
                           (i_reg_addr == psc_pkg::PINSEL_OFFS) ? pinsel_q : 8'h00;
      end
   end

   // Checks
   // Busy is sampled high on the last cycle of the sequencer count, then low
   chk_reload_clears: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      reload_go_w && !reload_busy |-> ##16 reload_busy ##1 !reload_busy)
      else $error("reload bit did not clear on time");
   chk_reload_starts: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      reload_go_w && !reload_busy |=> reload_busy)
      else $error("reload did not start");
   chk_trim_copy: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      reload_done |=> o_trim == $past(i_trim_nv))
      else $error("trim not copied");
   chk_clear_defaults: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      clear_go_w && !clear_busy
      |=> (ctrl_q == psc_pkg::CTRL_RST && pinsel_q == psc_pkg::PINSEL_RST)
      ##3 clear_busy ##1 !clear_busy)
      else $error("soft clear misbehaved");
   chk_fast_no_noise: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      fast_rate_w |=> !o_low_noise)
      else $error("low noise active at fast rate");
   chk_shot_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      o_shot_start |-> $past(powered_dn_w))
      else $error("shot started outside power down");
   chk_shot_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      shot_busy_q && i_shot_done && !shot_go_w |=> !shot_busy_q)
      else $error("shot bit did not self clear");
   chk_pin_high_src: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      src_w == psc_pkg::SRC_PHIGH
      |=> o_event_out_pin == ($past(i_press_high) ^ $past(active_lo_w)))
      else $error("pin does not follow pressure high");
   // Idle open drain pulls low only for active high polarity
   chk_pin_opendrain: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      open_dr_w && !event_w |=> o_event_out_pin_oe == !$past(active_lo_w))
      else $error("open drain idle drive wrong");
   chk_ainc_out: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      wr_ctrl_w && !clear_go_w
      |=> ##1 o_addr_inc_en == $past(i_reg_wdata[psc_pkg::CTL_AINC_BIT], 2))
      else $error("auto increment not applied");
endmodule : psc_regs
`default_nettype wire

// *** tb/psc_conv_model.sv ***
// Conversion engine stand-in: answers each shot start with a done pulse.
// Assumes start is a one-cycle pulse on i_clock; i_slow picks a long answer.
`timescale 1ns/1ps
`default_nettype none
module psc_conv_model (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Shot handshake
   input  wire logic i_start,
   input  wire logic i_slow,
   output logic      o_done
);
   int cnt_q;

   // Done marks results loaded; slow mode keeps the trigger pending longer
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cnt_q  <= 0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= (cnt_q == 1);
         if (i_start)
            cnt_q <= i_slow ? 20 : 2;
         else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
      end
   end
endmodule : psc_conv_model
`default_nettype wire

// *** tb/psc_regs_tb.sv ***
// Self-checking bench for the control register pair and the pin router.
// Assumes the conversion model answers shots; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module psc_regs_tb;
   logic        i_clock, i_sys_rst, wr_s, rd_s, inc_en, sclr, shot, done, lnoise, slow, pin, oe;
   logic [7:0]  addr, wdata, rdata, r;
   logic [2:0]  rate;
   logic [63:0] trim_nv, trim;
   logic [5:0]  ev;
   logic [31:0] seed = 32'ha27b;
   int          mismatches, n_compared, ctl, ps, w, shots, clears, i, k, base;

   psc_regs #(.TRIM_WORDS(8)) u_psc_regs (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_addr_inc_en(inc_en), .i_output_rate_field(rate),
      .i_trim_nv(trim_nv), .o_trim(trim), .o_soft_reg_clear(sclr), .o_shot_start(shot),
      .i_shot_done(done), .o_low_noise(lnoise), .i_data_ready(ev[0]),
      .i_fifo_level_mark(ev[1]), .i_fifo_overrun(ev[2]), .i_fifo_full(ev[3]),
      .i_press_high(ev[4]), .i_press_low(ev[5]), .o_event_out_pin(pin),
      .o_event_out_pin_oe(oe));
   psc_conv_model u_psc_conv_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_start(shot), .i_slow(slow), .o_done(done));

   // Free-running 50 MHz clock
   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   // Count shot pulses and clear cycles as the design drives them
   always @(posedge i_clock)
   begin
      if (shot === 1'b1) shots++;
      if (sclr === 1'b1) clears++;
   end

   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : nxt

   // Expected {oe, pin} from the routing model
   function automatic logic [1:0] pin_exp();
      logic e;
      case (ps & 3)
         0:       e = (ev[0] && ps[2]) || (ev[1] && ps[4]) || (ev[2] && ps[3]) || (ev[3] && ps[5]);
         1:       e = ev[4];
         2:       e = ev[5];
         default: e = ev[4] || ev[5];
      endcase
      e = e ^ ctl[6];
      return {(ctl[5] ? ~e : 1'b1), e};
   endfunction : pin_exp

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      addr  = a;
      wdata = d;
      wr_s  = 1'b1;
      @(negedge i_clock);
      wr_s  = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clock);
      addr = a;
      rd_s = 1'b1;
      @(negedge i_clock);
      rd_s = 1'b0;
      d    = rdata;
   endtask : rd

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   initial
   begin
      mismatches = 0; n_compared = 0; i_sys_rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0;
      addr = 8'h00; wdata = 8'h00; rate = 3'h0; trim_nv = '0; ev = '0; slow = 1'b0;
      repeat (10) @(negedge i_clock);
      i_sys_rst = 1'b0;
      // Reset values, unmapped read
      chk({oe, pin, inc_en}, 3'b101);
      chk(trim, 64'h0);
      rd(8'h11, r); chk(r, 8'h10);
      rd(8'h12, r); chk(r, 8'h00);
      rd(8'h40, r); chk(r, 8'h00);
      // Random modes, routes, rates and events; bit 3 must never store
      for (i = 0; i < 40; i++)
      begin
         rate = 3'h0;
         w = nxt() & 'h7A;
         ctl = w & 'h72;
         wr(8'h11, w[7:0]);
         ps = nxt();
         wr(8'h12, ps[7:0]);
         ps = ps & 'h3F;
         rate = nxt();
         ev = nxt();
         repeat (2) @(negedge i_clock);
         chk({oe, pin}, pin_exp());
         chk(lnoise, ctl[1] && rate < 3'h6);
         chk(inc_en, ctl[4]);
         rd(8'h11, r); chk(r, ctl[7:0]);
         rd(8'h12, r); chk(r, ps[7:0]);
      end
      // Trim reload, then hardware clear of the reload bit
      trim_nv = {nxt(), nxt()};
      rate = 3'h0;
      wr(8'h11, 8'h80);
      rd(8'h11, r); chk(r[7], 1'b1);
      k = 0;
      while (r[7] !== 1'b0 && k < 40)
      begin
         rd(8'h11, r);
         k++;
      end
      chk(k < 40, 1'b1);
      chk(trim, trim_nv);
      // Soft clear restores both registers and pulses for the clear count
      wr(8'h12, 8'h3F);
      base = clears;
      wr(8'h11, 8'h04);
      k = 0;
      do
      begin
         @(negedge i_clock);
         k++;
      end
      while ((clears == base || sclr !== 1'b0) && k < 20);
      chk(clears - base, psc_pkg::CLEAR_CYCLES);
      rd(8'h11, r); chk(r, 8'h10);
      rd(8'h12, r); chk(r, 8'h00);
      // Single shot, prompt and slow engine
      for (i = 0; i < 2; i++)
      begin
         slow = i[0];
         base = shots;
         wr(8'h11, 8'h01);
         rd(8'h11, r); chk(r[0], 1'b1);
         k = 0;
         while (done !== 1'b1 && k < 40)
         begin
            @(negedge i_clock);
            k++;
         end
         rd(8'h11, r); chk(r[0], 1'b0);
         chk(shots - base, 1);
      end
      // Shot outside power-down is ignored
      base = shots;
      rate = 3'h1;
      wr(8'h11, 8'h01);
      repeat (5) @(negedge i_clock);
      chk(shots - base, 0);
      rd(8'h11, r); chk(r[0], 1'b0);
      end_of_test();
   end
endmodule : psc_regs_tb
`default_nettype wire
